// File: sfc_params.svh
// constants of the serial flash command interface: opcodes, bus offsets,
// status fields, reset values and timing figures
// assumes: included by the package user, pclk at SFC_CLK_MHZ
`ifndef SFC_PARAMS_SVH
`define SFC_PARAMS_SVH

`define SFC_OP_WRITE_ENABLE_CMD   8'h06
`define SFC_OP_WRITE_DISABLE_CMD   8'h04
`define SFC_OP_STATUS_WRITE_CMD   8'h01
`define SFC_OP_JEDEC  8'h9F
`define SFC_OP_STATUS_READ_CMD   8'h05
`define SFC_OP_READ   8'h03
`define SFC_OP_FAST   8'h0B
`define SFC_OP_DUAL   8'h3B
`define SFC_OP_SECT   8'h20
`define SFC_OP_BLK_A  8'h52
`define SFC_OP_BLK_B  8'hD8
`define SFC_OP_CHIP_A 8'h60
`define SFC_OP_CHIP_B 8'hC7
`define SFC_OP_PAGE   8'h02
`define SFC_OP_SLEEP  8'hB9
`define SFC_OP_WAKE   8'hAB
`define SFC_OP_MFRDEV 8'h90
`define SFC_OP_SECRD  8'h2B
`define SFC_OP_SECWR  8'h2F
`define SFC_OP_OTPIN  8'hB1
`define SFC_OP_OTPOUT 8'hC1

`define SFC_REG_CTRL   8'h00
`define SFC_REG_ID     8'h04
`define SFC_REG_STATUS 8'h08
`define SFC_CTRL_RST   32'h0000_0000
`define SFC_ID_RST     24'h00_3C_5A
`define SFC_PIN_RST    4'h9

`define SFC_ST_BUSY 0
`define SFC_ST_WEL  1
`define SFC_ST_BP   2

`define SFC_SECT_BYTES 24'h00_1000
`define SFC_BLK_BYTES  24'h01_0000
`define SFC_PAGE_BYTES 24'h00_0100
`define SFC_CHIP_BYTES 24'h80_0000

`define SFC_CLK_MHZ    100
`define SFC_T_STATUS_WRITE_CMD_US  10
`define SFC_T_PAGE_US  1400
`define SFC_T_SECT_US  60000
`define SFC_T_BLK_US   700000
`define SFC_T_CHIP_US  20000000

`endif

// File: sfc_pkg.sv
// types of the serial flash command interface
// assumes: nothing beyond the constants header
package sfc_pkg;
	typedef enum logic [3:0] {
		SFC_IDLE  = 4'b0001,
		SFC_STAT  = 4'b0010,
		SFC_PROG  = 4'b0100,
		SFC_ERASE = 4'b1000
	} sfc_op_type;
	typedef logic [7:0] sfc_byte_type;
endpackage : sfc_pkg

// File: sfc_flash_if.sv
// serial flash command interface, device side, with its array in flops
// assumes: pins are asynchronous to pclk; serial clock well below pclk/6;
// registers reached over apb
`timescale 1ns/1ps
`default_nettype none
`include "sfc_params.svh"

module sfc_flash_if import sfc_pkg::*; #(
	parameter int          MEM_AW   = 23,
	parameter int          CLK_MHZ  = `SFC_CLK_MHZ,
	parameter int unsigned STATUS_WRITE_CMD_CYC = `SFC_T_STATUS_WRITE_CMD_US * CLK_MHZ,
	parameter int unsigned PAGE_CYC = `SFC_T_PAGE_US * CLK_MHZ,
	parameter int unsigned SECT_CYC = `SFC_T_SECT_US * CLK_MHZ,
	parameter int unsigned BLK_CYC  = `SFC_T_BLK_US * CLK_MHZ,
	parameter int unsigned CHIP_CYC = `SFC_T_CHIP_US * CLK_MHZ
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        chip_select_n,
	input  wire logic        serial_clk,
	input  wire logic        pause_n,
	input  wire logic        host_to_dev_io0,
	output logic             io0_out,
	output logic             io0_oe,
	output logic             dev_to_host_io1,
	output logic             dev_to_host_io1_oe
);

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [3:0] pin_in;
	logic [3:0] s1_q, s2_q, s3_q, flt_q, prv_q;
	assign pin_in = {pause_n, host_to_dev_io0, serial_clk, chip_select_n};

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_sync
			localparam logic [3:0] RV = `SFC_PIN_RST;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					s1_q[g]  <= RV[g];
					s2_q[g]  <= RV[g];
					s3_q[g]  <= RV[g];
					flt_q[g] <= RV[g];
					prv_q[g] <= RV[g];
				end else if (clk_en) begin
					s1_q[g] <= pin_in[g];
					s2_q[g] <= s1_q[g];
					s3_q[g] <= s2_q[g];
					// a change counts once stages two and three agree
					if (s2_q[g] == s3_q[g])
						flt_q[g] <= s3_q[g];
					prv_q[g] <= flt_q[g];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------
	function automatic logic [2:0] hdr_len(input sfc_byte_type op);
		case (op)
			`SFC_OP_STATUS_READ_CMD, `SFC_OP_JEDEC, `SFC_OP_SECRD: hdr_len = 3'd1;
			`SFC_OP_READ, `SFC_OP_MFRDEV, `SFC_OP_WAKE: hdr_len = 3'd4;
			`SFC_OP_FAST, `SFC_OP_DUAL: hdr_len = 3'd5;
			default: hdr_len = 3'd0;
		endcase
	endfunction : hdr_len

	function automatic logic is_array(input sfc_byte_type op);
		case (op)
			`SFC_OP_READ, `SFC_OP_FAST, `SFC_OP_DUAL, `SFC_OP_SECT,
			`SFC_OP_BLK_A, `SFC_OP_BLK_B, `SFC_OP_CHIP_A, `SFC_OP_CHIP_B,
			`SFC_OP_PAGE, `SFC_OP_STATUS_WRITE_CMD: is_array = 1'b1;
			default: is_array = 1'b0;
		endcase
	endfunction : is_array

	function automatic logic is_known(input sfc_byte_type op);
		is_known = is_array(op) || hdr_len(op) != 3'd0 ||
			op == `SFC_OP_WRITE_ENABLE_CMD || op == `SFC_OP_WRITE_DISABLE_CMD ||
			op == `SFC_OP_SLEEP || op == `SFC_OP_SECWR ||
			op == `SFC_OP_OTPIN || op == `SFC_OP_OTPOUT;
	endfunction : is_known

	// level 1-6 guard the top blocks, 9-14 the bottom, 7/8/15 all
	function automatic logic prot_hit(input logic [3:0] lvl,
		input logic [6:0] blk);
		logic [7:0] span;
		span = 8'd0;
		if (lvl == 4'd0)
			prot_hit = 1'b0;
		else if (lvl == 4'd7 || lvl == 4'd8 || lvl == 4'd15)
			prot_hit = 1'b1;
		else if (lvl < 4'd7) begin
			span = 8'(8'd1 << lvl);
			prot_hit = {1'b0, blk} >= 8'(8'd128 - span);
		end else begin
			span = 8'(8'd1 << (4'd15 - lvl));
			prot_hit = {1'b0, blk} < 8'(8'd128 - span);
		end
	endfunction : prot_hit

	function automatic logic [23:0] cap_len(input logic [23:0] len);
		logic [24:0] lim;
		lim = 25'(25'd1 << MEM_AW);
		cap_len = ({1'b0, len} > lim) ? 24'(lim) : len;
	endfunction : cap_len

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	sfc_byte_type mem_q [2**MEM_AW];
	sfc_byte_type pbuf_q [256];
	sfc_op_type   op_q;
	logic [31:0]  cnt_q;
	logic [23:0]  left_q, walk_q, addr_q;
	logic [2:0]   bit_q, nbyte_q, obit_q;
	logic [1:0]   dcnt_q;
	sfc_byte_type shin_q, cmd_q, obyte_q, srdat_q;
	logic [3:0]   bp_q;
	logic         wel_q, stby_q, act_q, outph_q, paused_q;
	logic         sleep_q, otp_q, seclk_q, io1_q, io0_q, oe1_q, oe0_q;
	logic [31:0]  ctrl_q, prdata_q;
	logic [23:0]  id_q;
	logic         pready_q, pslverr_q;

	// ------------------------------------------------------------
	// link events and decode
	// ------------------------------------------------------------
	logic cs_hi, cs_rise, cs_fall, shift_en, rise, fall, busy, dual;
	logic byte_done, op_ok, hdr_end;
	sfc_byte_type byte_in, st_byte, f_cmd, hdr_data, nxt_data;
	logic [23:0] f_addr;

	assign cs_hi     = flt_q[0];
	assign cs_rise   = flt_q[0] & ~prv_q[0];
	assign cs_fall   = ~flt_q[0] & prv_q[0];
	assign shift_en  = ~cs_hi & ~paused_q & ~stby_q;
	assign rise      = shift_en & flt_q[1] & ~prv_q[1];
	assign fall      = shift_en & ~flt_q[1] & prv_q[1];
	assign busy      = op_q != SFC_IDLE;
	assign dual      = cmd_q == `SFC_OP_DUAL;
	assign byte_in   = {shin_q[6:0], flt_q[2]};
	assign byte_done = rise && bit_q == 3'd7;
	assign st_byte   = {2'b00, bp_q, wel_q, busy};
	// asleep: only wake; busy: no array access, no writes
	assign op_ok = is_known(byte_in) &&
		(!sleep_q || byte_in == `SFC_OP_WAKE) &&
		!(busy && (is_array(byte_in) || byte_in == `SFC_OP_WRITE_ENABLE_CMD));
	assign f_cmd   = (nbyte_q == 3'd0) ? byte_in : cmd_q;
	assign f_addr  = (nbyte_q == 3'd3) ? {addr_q[15:0], byte_in} : addr_q;
	assign hdr_end = byte_done && hdr_len(f_cmd) != 3'd0 &&
		3'(nbyte_q + 3'd1) == hdr_len(f_cmd) &&
		(nbyte_q != 3'd0 || op_ok);

	function automatic sfc_byte_type fetch(input sfc_byte_type op,
		input logic [23:0] a, input logic [1:0] idx);
		case (op)
			`SFC_OP_STATUS_READ_CMD:  fetch = st_byte;
			`SFC_OP_SECRD: fetch = {6'd0, seclk_q, 1'b0};
			`SFC_OP_JEDEC: fetch = (idx == 2'd0) ? id_q[7:0] :
				(idx == 2'd1) ? id_q[15:8] : id_q[23:16];
			`SFC_OP_WAKE:  fetch = id_q[23:16];
			`SFC_OP_MFRDEV: fetch = a[0] ? id_q[23:16] : id_q[7:0];
			// secured area contents are not modelled: read as erased
			default: fetch = otp_q ? 8'hFF : mem_q[a[MEM_AW-1:0]];
		endcase
	endfunction : fetch

	assign hdr_data = fetch(f_cmd, f_addr, dcnt_q);
	assign nxt_data = fetch(cmd_q, addr_q, dcnt_q);

	// ------------------------------------------------------------
	// command framing and output shifting
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bit_q <= 3'd0; nbyte_q <= 3'd0; shin_q <= 8'h00;
			cmd_q <= 8'h00; addr_q <= 24'h00_0000; srdat_q <= 8'h00;
			stby_q <= 1'b0; act_q <= 1'b0; outph_q <= 1'b0;
			obyte_q <= 8'h00; obit_q <= 3'd0; dcnt_q <= 2'd0;
			paused_q <= 1'b0;
		end else if (clk_en) begin
			if (cs_hi) begin
				paused_q <= 1'b0;
			end else if (!flt_q[1]) begin
				paused_q <= ~flt_q[3];
			end
			if (cs_fall)
				stby_q <= 1'b0;
			if (cs_hi) begin
				bit_q <= 3'd0; nbyte_q <= 3'd0;
				act_q <= 1'b0; outph_q <= 1'b0; dcnt_q <= 2'd0;
			end else if (rise && !outph_q) begin
				shin_q <= byte_in;
				bit_q  <= 3'(bit_q + 3'd1);
				if (byte_done) begin
					if (nbyte_q != 3'd7)
						nbyte_q <= 3'(nbyte_q + 3'd1);
					if (nbyte_q == 3'd0) begin
						cmd_q  <= byte_in;
						act_q  <= op_ok;
						stby_q <= ~op_ok;
					end else if (nbyte_q == 3'd1)
						srdat_q <= byte_in;
					if (nbyte_q >= 3'd1 && nbyte_q <= 3'd3)
						addr_q <= {addr_q[15:0], byte_in};
					else if (nbyte_q >= 3'd4)
						addr_q[7:0] <= 8'(addr_q[7:0] + 8'd1);
					if (hdr_end) begin
						outph_q <= 1'b1;
						obyte_q <= hdr_data;
						obit_q  <= 3'd0;
						addr_q  <= 24'(f_addr + 24'd1);
						dcnt_q  <= 2'd1;
					end
				end
			end else if (fall && outph_q) begin
				io_shift();
			end
		end
	end

	// one or two bits leave per falling edge; refill at each byte end
	task automatic io_shift();
		logic last;
		last = dual ? (obit_q == 3'd6) : (obit_q == 3'd7);
		obyte_q <= dual ? {obyte_q[5:0], 2'b00} : {obyte_q[6:0], 1'b0};
		obit_q  <= 3'(obit_q + (dual ? 3'd2 : 3'd1));
		if (last) begin
			obyte_q <= nxt_data;
			obit_q  <= 3'd0;
			// whole-array wrap keeps a read running indefinitely
			addr_q  <= {1'b0, 23'(addr_q[22:0] + 23'd1)};
			dcnt_q  <= (dcnt_q == 2'd2) ? 2'd0 : 2'(dcnt_q + 2'd1);
		end
	endtask : io_shift

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			io1_q <= 1'b0; io0_q <= 1'b0; oe1_q <= 1'b0; oe0_q <= 1'b0;
		end else if (clk_en) begin
			if (fall && outph_q) begin
				io1_q <= obyte_q[7];
				io0_q <= obyte_q[6];
			end
			// released at once on deselect, so any bit may end it
			oe1_q <= shift_en & outph_q;
			oe0_q <= shift_en & outph_q & dual;
		end
	end

	// ------------------------------------------------------------
	// execution on deselect, self-timed operations
	// ------------------------------------------------------------
	logic exec, blk_prot, may_write;
	assign exec = cs_rise & act_q & ~stby_q & ~outph_q &&
		bit_q == 3'd0;
	assign blk_prot  = prot_hit(bp_q, addr_q[22:16]);
	assign may_write = wel_q & ~otp_q & ~busy;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_q <= SFC_IDLE; cnt_q <= 32'h0000_0000;
			left_q <= 24'h00_0000; walk_q <= 24'h00_0000;
			wel_q <= 1'b0; bp_q <= 4'h0;
			sleep_q <= 1'b0; otp_q <= 1'b0; seclk_q <= 1'b0;
		end else if (clk_en) begin
			if (op_q != SFC_IDLE) begin
				// erase/program walk; verify is implicit in flop storage
				if (left_q != 24'h00_0000) begin
					left_q <= 24'(left_q - 24'd1);
					walk_q <= 24'(walk_q + 24'd1);
				end
				if (cnt_q != 32'h0000_0000)
					cnt_q <= 32'(cnt_q - 32'd1);
				if (left_q == 24'h00_0000 && cnt_q == 32'h0000_0000)
					op_q <= SFC_IDLE;
			end
			if (cs_rise && cmd_q == `SFC_OP_WAKE && act_q)
				sleep_q <= 1'b0;
			if (exec) begin
				case (cmd_q)
					`SFC_OP_WRITE_ENABLE_CMD: wel_q <= 1'b1;
					`SFC_OP_WRITE_DISABLE_CMD: wel_q <= 1'b0;
					`SFC_OP_STATUS_WRITE_CMD:
						if (may_write && nbyte_q >= 3'd2 && !ctrl_q[0]) begin
							bp_q  <= srdat_q[5:2];
							wel_q <= 1'b0;
							op_q  <= SFC_STAT;
							cnt_q <= STATUS_WRITE_CMD_CYC;
						end
					`SFC_OP_SECT:
						if (may_write && nbyte_q == 3'd4 && !blk_prot) begin
							walk_q <= {addr_q[23:12], 12'h000};
							left_q <= cap_len(`SFC_SECT_BYTES);
							op_q   <= SFC_ERASE;
							cnt_q  <= SECT_CYC;
							wel_q  <= 1'b0;
						end
					`SFC_OP_BLK_A, `SFC_OP_BLK_B:
						if (may_write && nbyte_q == 3'd4 && !blk_prot) begin
							walk_q <= {addr_q[23:16], 16'h0000};
							left_q <= cap_len(`SFC_BLK_BYTES);
							op_q   <= SFC_ERASE;
							cnt_q  <= BLK_CYC;
							wel_q  <= 1'b0;
						end
					`SFC_OP_CHIP_A, `SFC_OP_CHIP_B:
						if (may_write && bp_q == 4'h0) begin
							walk_q <= 24'h00_0000;
							left_q <= cap_len(`SFC_CHIP_BYTES);
							op_q   <= SFC_ERASE;
							cnt_q  <= CHIP_CYC;
							wel_q  <= 1'b0;
						end
					`SFC_OP_PAGE:
						if (may_write && nbyte_q >= 3'd5 && !blk_prot) begin
							walk_q <= {addr_q[23:8], 8'h00};
							left_q <= `SFC_PAGE_BYTES;
							op_q   <= SFC_PROG;
							cnt_q  <= PAGE_CYC;
							wel_q  <= 1'b0;
						end
					`SFC_OP_SLEEP: sleep_q <= 1'b1;
					`SFC_OP_OTPIN: otp_q <= 1'b1;
					`SFC_OP_OTPOUT: otp_q <= 1'b0;
					`SFC_OP_SECWR: if (wel_q) seclk_q <= 1'b1;
					default: ;
				endcase
			end
		end
	end

	// page buffer: unloaded bytes stay ff and leave the array unchanged
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 256; i++)
				pbuf_q[i] <= 8'hFF;
		end else if (clk_en && rise && !outph_q && byte_done) begin
			if (nbyte_q == 3'd0 && byte_in == `SFC_OP_PAGE)
				for (int i = 0; i < 256; i++)
					pbuf_q[i] <= 8'hFF;
			else if (nbyte_q >= 3'd4 && cmd_q == `SFC_OP_PAGE)
				pbuf_q[addr_q[7:0]] <= byte_in;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 2**MEM_AW; i++)
				mem_q[i] <= 8'hFF;
		end else if (clk_en && left_q != 24'h00_0000) begin
			if (op_q == SFC_ERASE)
				mem_q[walk_q[MEM_AW-1:0]] <= 8'hFF;
			else if (op_q == SFC_PROG)
				mem_q[walk_q[MEM_AW-1:0]] <= mem_q[walk_q[MEM_AW-1:0]] &
					pbuf_q[walk_q[7:0]];
		end
	end

	// ------------------------------------------------------------
	// apb slave
	// ------------------------------------------------------------
	logic sel_ctrl, sel_id, sel_st, wr_acc, bad;
	logic [31:0] rd_mux;
	assign sel_ctrl = paddr == `SFC_REG_CTRL;
	assign sel_id   = paddr == `SFC_REG_ID;
	assign sel_st   = paddr == `SFC_REG_STATUS;
	assign bad      = !(sel_ctrl || sel_id || sel_st) || (sel_st && pwrite);
	assign wr_acc   = psel & penable & pready_q & pwrite & ~bad;
	assign rd_mux   = sel_ctrl ? ctrl_q : sel_id ? {8'h00, id_q} :
		sel_st ? {20'h0_0000, seclk_q, otp_q, sleep_q, stby_q, st_byte} :
		32'h0000_0000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `SFC_CTRL_RST; id_q <= `SFC_ID_RST;
			prdata_q <= 32'h0000_0000; pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else if (clk_en) begin
			pready_q  <= psel & ~penable & ~pready_q;
			pslverr_q <= psel & ~penable & bad;
			if (psel && !penable)
				prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
			if (wr_acc && sel_ctrl)
				ctrl_q <= {31'h0000_0000, pwdata[0]};
			if (wr_acc && sel_id)
				id_q <= pwdata[23:0];
		end
	end

	assign prdata             = prdata_q;
	assign pready             = pready_q;
	assign pslverr            = pslverr_q;
	assign io0_out            = io0_q;
	assign io0_oe             = oe0_q;
	assign dev_to_host_io1    = io1_q;
	assign dev_to_host_io1_oe = oe1_q;

endmodule : sfc_flash_if
`default_nettype wire

// File: sfc_flash_if_assertions.sv
// checker of the flash command interface, watching its ports only
// assumes: bound to sfc_flash_if, one pclk domain
`timescale 1ns/1ps
`default_nettype none

module sfc_flash_if_chk (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        clk_en,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        chip_select_n,
	input wire logic        io0_oe,
	input wire logic        dev_to_host_io1_oe
);
	logic setup;
	logic mapped;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	assign setup  = psel && !penable && clk_en;
	assign mapped = paddr inside {8'h00, 8'h04, 8'h08};

	// --------------------
	// register bus
	// --------------------
	property p_ready_next;
		setup |=> pready;
	endproperty
	a_ready_next: assert property (p_ready_next) else $error("ready late");
	property p_ready_pulse;
		pready |=> !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
	property p_err_unmapped;
		setup && !mapped |=> pslverr && (pwrite || prdata == 32'h0000_0000);
	endproperty
	a_err_unmapped: assert property (p_err_unmapped) else $error("no error");
	property p_status_ro;
		setup && pwrite && paddr == 8'h08 |=> pslverr;
	endproperty
	a_status_ro: assert property (p_status_ro) else $error("status written");
	property p_ok_mapped;
		setup && paddr inside {8'h00, 8'h04} |=> !pslverr;
	endproperty
	a_ok_mapped: assert property (p_ok_mapped) else $error("false error");

	// --------------------
	// serial link
	// --------------------
	property p_idle_quiet;
		chip_select_n [*8] |-> !dev_to_host_io1_oe && !io0_oe;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("drives idle");
	property p_oe_after_header;
		$rose(dev_to_host_io1_oe) |-> !chip_select_n && !$past(chip_select_n, 8);
	endproperty
	a_oe_after_header: assert property (p_oe_after_header) else $error("early");
	property p_dual_pair;
		$rose(io0_oe) |-> ##[0:2] dev_to_host_io1_oe;
	endproperty
	a_dual_pair: assert property (p_dual_pair) else $error("io1 off");
endmodule : sfc_flash_if_chk

bind sfc_flash_if sfc_flash_if_chk sfc_flash_if_chk_i (
	.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .prdata,
	.pready, .pslverr, .chip_select_n, .io0_oe, .dev_to_host_io1_oe
);

`default_nettype wire

// File: sfc_host_model.sv
// host side of the serial link: mode 0 or 3, single or dual reads
// assumes: pclk at 100 MHz, bench resolves the shared io0 wire
`timescale 1ns/1ps
`default_nettype none

module sfc_host_model (
	input  wire logic pclk,
	input  wire logic dev_to_host_io1,
	input  wire logic io0_wire,
	output logic      chip_select_n,
	output logic      serial_clk,
	output logic      pause_n,
	output logic      host_io0
);
	initial begin
		chip_select_n = 1'b1;
		serial_clk    = 1'b0;
		pause_n       = 1'b1;
		host_io0      = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask : tick

	// sample late in the high phase: device output lags its clock fall
	task automatic bit_cyc(input logic d, output logic [1:0] s);
		serial_clk <= 1'b0;
		host_io0   <= d;
		tick(4);
		serial_clk <= 1'b1;
		tick(3);
		@(negedge pclk) s = {dev_to_host_io1, io0_wire};
		@(posedge pclk);
	endtask : bit_cyc

	task automatic run(input logic [47:0] h, input int nt, input int xb,
		input int nr, input bit dual, input bit md3, input bit pz,
		output logic [31:0] rx);
		int         i;
		logic [1:0] s;
		rx = 32'h0000_0000;
		@(posedge pclk);
		// idle level settles before select falls: no false first edge
		serial_clk    <= md3;
		tick(4);
		chip_select_n <= 1'b0;
		tick(4);
		for (i = 0; i < nt * 8 + xb; i++) begin
			if (pz && i == 8) begin
				serial_clk <= 1'b0;
				tick(4);
				pause_n <= 1'b0;
				tick(4);
				repeat (2) bit_cyc(1'b1, s);
				serial_clk <= 1'b0;
				tick(4);
				pause_n <= 1'b1;
			end
			bit_cyc(h[47 - i], s);
		end
		// released io0 toggles so a stale level never reads as data
		for (i = 0; i < nr; i++) begin
			bit_cyc(~host_io0, s);
			rx = dual ? {rx[29:0], s} : {rx[30:0], s[1]};
		end
		if (!md3)
			serial_clk <= 1'b0;
		tick(4);
		chip_select_n <= 1'b1;
		host_io0      <= ~host_io0;
		tick(8);
	endtask : run
endmodule : sfc_host_model

`default_nettype wire

// File: sfc_flash_if_bench.sv
// self-checking bench of the flash command interface
// assumes: 8K array and short operation times set below
`timescale 1ns/1ps
`default_nettype none
`include "sfc_params.svh"

module sfc_flash_if_bench import sfc_pkg::*;;
	localparam logic [23:0] ID_VAL = 24'h12_3456; // arbitrary code
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        clk_en = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, r;
	logic        pready, pslverr, e, oe_seen;
	logic        cs_n, sclk, pause_n, h_io0, io0_w;
	logic        io0_out, io0_oe, io1, io1_oe, io1_w;
	int          miscompares = 0;
	int          checked = 0;

	always #5 pclk = ~pclk;
	assign io0_w = io0_oe ? io0_out : h_io0;
	// released io1 shows the inverse, so a stale bit never reads as data
	assign io1_w = io1_oe ? io1 : ~io1;
	always @(posedge pclk)
		if (io1_oe === 1'b1)
			oe_seen <= 1'b1;

	sfc_flash_if #(.MEM_AW(13), .PAGE_CYC(600),
		.SECT_CYC(300), .BLK_CYC(300), .CHIP_CYC(300)) sfc_flash_if_i (
		.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .chip_select_n(cs_n),
		.serial_clk(sclk), .pause_n, .host_to_dev_io0(io0_w), .io0_out,
		.io0_oe, .dev_to_host_io1(io1), .dev_to_host_io1_oe(io1_oe));
	sfc_host_model sfc_host_model_i (.pclk, .dev_to_host_io1(io1_w),
		.io0_wire(io0_w), .chip_select_n(cs_n), .serial_clk(sclk),
		.pause_n, .host_io0(h_io0));

	// --------------------
	// shared tasks
	// --------------------
	task automatic stop_test;
		if (miscompares == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : stop_test

	task automatic chk(input string nm, input logic [31:0] ex, got);
		checked++;
		if (got !== ex) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		if (n == 20) begin
			miscompares++;
			stop_test();
		end
	endtask : apb

	task automatic st(input logic [31:0] ex);
		apb(1'b0, `SFC_REG_STATUS, 32'h0000_0000);
		chk("status", ex, r);
	endtask : st

	task automatic sp(input logic [47:0] h, input int nt, xb, nr,
		input bit dual, md3, pz);
		sfc_host_model_i.run(h, nt, xb, nr, dual, md3, pz, r);
	endtask : sp

	task automatic op1(input logic [7:0] c);
		sp({c, 40'h0}, 1, 0, 0, 0, 0, 0);
	endtask : op1

	task automatic rd(input logic [23:0] a, input int n);
		sp({`SFC_OP_READ, a, 16'h0}, 4, 0, n * 8, 0, 0, 0);
	endtask : rd

	task automatic wait_idle;
		int n;
		for (n = 0; n < 3000; n++) begin
			apb(1'b0, `SFC_REG_STATUS, 32'h0000_0000);
			if (r[0] === 1'b0)
				break;
		end
		if (n == 3000) begin
			miscompares++;
			stop_test();
		end
	endtask : wait_idle

	// --------------------
	// scenarios
	// --------------------
	task automatic s_regs;
		st(32'h0000_0000);
		apb(1'b0, `SFC_REG_CTRL, 32'h0000_0000);
		chk("ctrl", `SFC_CTRL_RST, r);
		apb(1'b1, `SFC_REG_ID, {8'h00, ID_VAL});
		apb(1'b0, `SFC_REG_ID, 32'h0000_0000);
		chk("id", {8'h00, ID_VAL}, r);
		apb(1'b0, 8'h40, 32'h0000_0000);
		chk("unmapped", 32'h0000_0001, {r[30:0], e});
		apb(1'b1, `SFC_REG_STATUS, 32'h0000_00FF);
		chk("status wr", 32'h0000_0001, {31'h0, e});
	endtask : s_regs

	task automatic s_ident;
		sp({`SFC_OP_JEDEC, 40'h0}, 1, 0, 24, 0, 1, 0);
		chk("jedec", {8'h00, ID_VAL[7:0], ID_VAL[15:8], ID_VAL[23:16]}, r);
		sp({`SFC_OP_MFRDEV, 40'h0}, 4, 0, 16, 0, 1, 0);
		chk("mfr dev", {16'h0, ID_VAL[7:0], ID_VAL[23:16]}, r);
		sp({`SFC_OP_WAKE, 40'h0}, 4, 0, 3, 0, 0, 0);
		chk("sig", {29'h0, ID_VAL[23:21]}, r);
	endtask : s_ident

	task automatic s_prog;
		op1(`SFC_OP_WRITE_ENABLE_CMD);
		sp({`SFC_OP_STATUS_READ_CMD, 40'h0}, 1, 0, 8, 0, 0, 0);
		chk("latch", 32'h0000_0002, r);
		sp({`SFC_OP_PAGE, 24'h00_1000, 16'hA53C}, 6, 0, 0, 0, 0,
			1);
		apb(1'b0, `SFC_REG_STATUS, 32'h0000_0000);
		chk("busy", 32'h0000_0001, {31'h0, r[0]});
		oe_seen <= 1'b0;
		rd(24'h00_1000, 1);
		chk("busy read", 32'h0000_0000, {31'h0, oe_seen});
		wait_idle();
		st(32'h0000_0100);
		rd(24'h00_1000, 3);
		chk("read", 32'h00A5_3CFF, r);
		sp({`SFC_OP_DUAL, 24'h00_1000, 16'h0}, 5, 0, 8, 1, 0, 0);
		chk("dual", 32'h0000_A53C, r);
	endtask : s_prog

	task automatic s_bound;
		sp({`SFC_OP_WRITE_ENABLE_CMD, 40'h0}, 1, 3, 0, 0, 0, 0);
		st(32'h0000_0000);
		sp({`SFC_OP_PAGE, 24'h00_1001, 16'h0}, 5, 0, 0, 0, 0, 0);
		st(32'h0000_0000);
		op1(`SFC_OP_WRITE_ENABLE_CMD);
		sp({`SFC_OP_PAGE, 24'h00_1001, 16'h0}, 5, 2, 0, 0, 0, 0);
		st(32'h0000_0002);
		op1(`SFC_OP_WRITE_DISABLE_CMD);
		st(32'h0000_0000);
		// frozen clock: a whole enable frame must leave no trace
		clk_en <= 1'b0;
		op1(`SFC_OP_WRITE_ENABLE_CMD);
		clk_en <= 1'b1;
		st(32'h0000_0000);
		oe_seen <= 1'b0;
		sp({8'hFF, 40'h0}, 1, 0, 16, 0, 0, 0);
		chk("bad drive", 32'h0000_0000, {31'h0, oe_seen});
		st(32'h0000_0100);
		sp({`SFC_OP_STATUS_READ_CMD, 40'h0}, 1, 0, 8, 0, 0, 0);
		chk("next cmd", 32'h0000_0000, r);
	endtask : s_bound

	task automatic s_erase;
		logic [7:0] ops [0:4];
		int         i;
		ops = '{`SFC_OP_SECT, `SFC_OP_BLK_A, `SFC_OP_BLK_B, `SFC_OP_CHIP_A,
			`SFC_OP_CHIP_B};
		op1(`SFC_OP_WRITE_ENABLE_CMD);
		sp({`SFC_OP_SECT, 24'h00_0000, 16'h0}, 4, 0, 0, 0, 0, 0);
		wait_idle();
		rd(24'h00_1000, 1);
		chk("other sector", 32'h0000_00A5, r);
		for (i = 0; i < 5; i++) begin
			op1(`SFC_OP_WRITE_ENABLE_CMD);
			sp({`SFC_OP_PAGE, 24'h00_1000, 16'h0}, 5, 0, 0, 0, 0, 0);
			wait_idle();
			op1(`SFC_OP_WRITE_ENABLE_CMD);
			sp({ops[i], 24'h00_1000, 16'h0}, i < 3 ? 4 : 1, 0, 0, 0, 0, 0);
			apb(1'b0, `SFC_REG_STATUS, 32'h0000_0000);
			chk("erase busy", 32'h0000_0001, {31'h0, r[0]});
			wait_idle();
			st(32'h0000_0000);
			rd(24'h00_1000, 1);
			chk("erased", 32'h0000_00FF, r);
		end
	endtask : s_erase

	task automatic s_prot;
		op1(`SFC_OP_WRITE_ENABLE_CMD);
		sp({`SFC_OP_STATUS_WRITE_CMD, 8'h3C, 32'h0}, 2, 0, 0, 0, 0, 0);
		wait_idle();
		st(32'h0000_003C);
		op1(`SFC_OP_WRITE_ENABLE_CMD);
		sp({`SFC_OP_SECT, 24'h00_1000, 16'h0}, 4, 0, 0, 0, 0, 0);
		st(32'h0000_003E);
		sp({`SFC_OP_STATUS_WRITE_CMD, 8'h00, 32'h0}, 2, 0, 0, 0, 0, 0);
		wait_idle();
		st(32'h0000_0000);
	endtask : s_prot

	task automatic s_modes;
		op1(`SFC_OP_SLEEP);
		op1(`SFC_OP_STATUS_READ_CMD);
		st(32'h0000_0300);
		sp({`SFC_OP_WAKE, 40'h0}, 4, 0, 0, 0, 0, 0);
		st(32'h0000_0000);
		// otp mode refuses array writes, latch stays set
		op1(`SFC_OP_OTPIN);
		op1(`SFC_OP_WRITE_ENABLE_CMD);
		sp({`SFC_OP_PAGE, 24'h00_1000, 16'h0}, 5, 0, 0, 0, 0, 0);
		st(32'h0000_0402);
		op1(`SFC_OP_OTPOUT);
		sp({`SFC_OP_FAST, 24'h00_1000, 16'h0}, 5, 0, 8, 0, 0, 0);
		chk("otp write", 32'h0000_00FF, r);
		op1(`SFC_OP_SECWR);
		sp({`SFC_OP_SECRD, 40'h0}, 1, 0, 8, 0, 0, 0);
		chk("lock", 32'h0000_0002, r);
		st(32'h0000_0802);
	endtask : s_modes

	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		s_regs();
		s_ident();
		s_prog();
		s_bound();
		s_erase();
		s_prot();
		s_modes();
		stop_test();
	end
endmodule : sfc_flash_if_bench

`default_nettype wire
